/* File: rtl/charger_defines.vh */
// constants for the charger set-point register block
// assumes one 100 MHz clock; smbus pins sampled as synchronous inputs
//
// Functional notes
// RULE_01: reject ceiling commands above cell-count limit
// RULE_02: reject at 0x1800, 0x2800, 0x4000 and above
// RULE_03: floor drops eight low bits, uses seven
// RULE_04: floor request above 19.2V saturates
// RULE_05: floor word bit 15 is ignored
// RULE_06: floor register at code 0x3e, write-word
// RULE_07: floor word is millivolts, 65.535V full scale
// RULE_08: floor step is 256mV from bit 8
// RULE_09: floor resets to cell-dependent default
// RULE_10: read-word returns stored register contents
// RULE_11: fill rate drops seven low bits, uses six
// RULE_12: fill rate step 128mA from bit 7
// RULE_13: fill rate above 8.064A saturates
// RULE_14: fill rate up to 128mA gives zero
// RULE_15: fill rate resets zero, gate high, charging off
// RULE_16: host writes non-zero fill rate to charge
// RULE_17: fill rate register at code 0x14, write-word
// RULE_18: rejected ceiling write is not acknowledged
// RULE_19: ceiling at 0x15, uses bits 14 to 4
// RULE_20: target only, address 0b0001001
// RULE_21: low byte first, msb first per byte
// RULE_22: commit only after both bytes acknowledged
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

// bus address and command codes
`define ADDR_SELF 7'h09
`define CMD_FILL 8'h14
`define CMD_CEIL 8'h15
`define CMD_FLOOR 8'h3e
`define BYTE_BITS 4'h8
`define LAST_TX_BIT 4'h7

// cell-count strap encodings
`define CELL_ONE 2'h0
`define CELL_TWO 2'h1
`define CELL_THREE 2'h2

// smallest rejected ceiling command per cell count
`define CEIL_REJ_1 16'h1800
`define CEIL_REJ_2 16'h2800
`define CEIL_REJ_3 16'h4000

// power-on values
`define CEIL_POR_1 16'h1000
`define CEIL_POR_2 16'h2000
`define CEIL_POR_3 16'h3000
`define FLOOR_POR_1 16'h0c00
`define FLOOR_POR_2 16'h1800
`define FLOOR_POR_3 16'h2400
`define FILL_POR 16'h0000

// field positions and limits
`define CEIL_MSB 14
`define CEIL_LSB 4
`define CEIL_MIN_MV 16'h0400
`define FLOOR_MSB 14
`define FLOOR_LSB 8
`define FLOOR_MAX_CODE 7'h4b
`define FILL_MSB 12
`define FILL_LSB 7
`define FILL_FULL_CODE 6'h3f
`define FILL_MAX_MA 16'h1f80
`define FILL_ZERO_MA 16'h0080

`endif

/* File: rtl/smbus_line_monitor.v */
// edge and bus-condition detector for the smbus clock and data lines
// assumes scl and sda already synchronous to core_clk
module smbus_line_monitor (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // bus lines
    input wire scl_in,
    input wire sda_in,
    // events, one cycle each
    output wire scl_rise,
    output wire scl_fall,
    output wire start_seen,
    output wire stop_seen
);

reg scl_prev;
reg sda_prev;

// -----------------------------------------------------------------
// previous line levels
// -----------------------------------------------------------------
always @(posedge core_clk)
begin
    if (srst)
    begin
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
    end
    else
    begin
        scl_prev <= scl_in;
        sda_prev <= sda_in;
    end
end

assign scl_rise = scl_in & ~scl_prev;
assign scl_fall = ~scl_in & scl_prev;
// data moving while clock stays high marks start or stop
assign start_seen = scl_in & scl_prev & sda_prev & ~sda_in;
assign stop_seen = scl_in & scl_prev & ~sda_prev & sda_in;

endmodule // smbus_line_monitor

/* File: rtl/charger_setpoint_registers.v */
// smbus target holding the charger ceiling, floor and fill-rate set points
// assumes srst marks power-up of the bus supply rail and that the
// cell-count strap is stable while srst is held
`include "charger_defines.vh"

module charger_setpoint_registers (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // cell-count strap
    input wire [1:0] cell_count,
    // smbus lines, data is open drain
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    // converter codes
    output reg [10:0] ceiling_converter_code,
    output reg [6:0] floor_converter_code,
    output reg [5:0] fill_rate_converter_code,
    // charge path control
    output reg battery_switch_gate,
    output reg charge_enable
);

// -----------------------------------------------------------------
// state and byte-kind codes
// -----------------------------------------------------------------
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_RX = 3'h1;
localparam [2:0] S_ACK = 3'h2;
localparam [2:0] S_TX = 3'h3;
localparam [2:0] S_TXACK = 3'h4;

localparam [1:0] K_ADDR = 2'h0;
localparam [1:0] K_CMD = 2'h1;
localparam [1:0] K_DLO = 2'h2;
localparam [1:0] K_DHI = 2'h3;

// -----------------------------------------------------------------
// decoding helpers
// -----------------------------------------------------------------
function [15:0] ceil_reject_limit;
    input [1:0] cells;
    begin
        case (cells)
            `CELL_TWO: ceil_reject_limit = `CEIL_REJ_2;
            `CELL_THREE: ceil_reject_limit = `CEIL_REJ_3;
            default: ceil_reject_limit = `CEIL_REJ_1;
        endcase
    end
endfunction

function [15:0] ceil_por;
    input [1:0] cells;
    begin
        case (cells)
            `CELL_TWO: ceil_por = `CEIL_POR_2;
            `CELL_THREE: ceil_por = `CEIL_POR_3;
            default: ceil_por = `CEIL_POR_1;
        endcase
    end
endfunction

function [15:0] floor_por;
    input [1:0] cells;
    begin
        case (cells)
            `CELL_TWO: floor_por = `FLOOR_POR_2;
            `CELL_THREE: floor_por = `FLOOR_POR_3;
            default: floor_por = `FLOOR_POR_1;
        endcase
    end
endfunction

function cmd_mapped;
    input [7:0] code;
    begin
        cmd_mapped = (code == `CMD_FILL) || (code == `CMD_CEIL) || (code == `CMD_FLOOR);
    end
endfunction

// -----------------------------------------------------------------
// storage
// -----------------------------------------------------------------
reg [15:0] ceiling_word;
reg [15:0] floor_word;
reg [15:0] fill_word;

reg [2:0] state;
reg [1:0] kind;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] cmd;
reg [7:0] lo_byte;
reg [15:0] write_word;
reg write_pending;
reg tx_after_ack;
reg idle_after_ack;
reg tx_hi;
reg master_ack;

wire scl_rise;
wire scl_fall;
wire start_seen;
wire stop_seen;

reg [15:0] read_word;
reg [10:0] next_ceiling_code;
reg [6:0] next_floor_code;
reg [5:0] next_fill_code;

wire [15:0] ceil_por_word = ceil_por(cell_count);
wire [15:0] floor_por_word = floor_por(cell_count);
wire [15:0] rx_word = {shreg, lo_byte};
wire ceil_rejected = (cmd == `CMD_CEIL) && (rx_word >= ceil_reject_limit(cell_count)); // RULE_01 RULE_02

assign sda_out = 1'b0;

smbus_line_monitor line_monitor (
    .core_clk(core_clk),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
);

// -----------------------------------------------------------------
// read-back mux
// -----------------------------------------------------------------
always @*
begin
    case (cmd)
        `CMD_FILL: read_word = fill_word; // RULE_10
        `CMD_CEIL: read_word = ceiling_word;
        `CMD_FLOOR: read_word = floor_word; // RULE_10
        default: read_word = 16'h0000;
    endcase
end

// -----------------------------------------------------------------
// converter decode
// -----------------------------------------------------------------
always @*
begin
    // values under 1024mV shut the regulator off
    if (ceiling_word < `CEIL_MIN_MV)
        next_ceiling_code = 11'h000;
    else
        next_ceiling_code = ceiling_word[`CEIL_MSB:`CEIL_LSB]; // RULE_19

    // bit 15 never reaches the floor converter
    if (floor_word[`FLOOR_MSB:`FLOOR_LSB] > `FLOOR_MAX_CODE) // RULE_05 RULE_07
        next_floor_code = `FLOOR_MAX_CODE; // RULE_04
    else
        next_floor_code = floor_word[`FLOOR_MSB:`FLOOR_LSB]; // RULE_03 RULE_08

    if (fill_word <= `FILL_ZERO_MA)
        next_fill_code = 6'h00; // RULE_14
    else if (fill_word > `FILL_MAX_MA)
        next_fill_code = `FILL_FULL_CODE; // RULE_13
    else
        next_fill_code = fill_word[`FILL_MSB:`FILL_LSB]; // RULE_11 RULE_12
end

always @(posedge core_clk)
begin
    if (srst)
    begin
        ceiling_converter_code <= ceil_por_word[`CEIL_MSB:`CEIL_LSB];
        floor_converter_code <= floor_por_word[`FLOOR_MSB:`FLOOR_LSB];
        fill_rate_converter_code <= 6'h00;
        battery_switch_gate <= 1'b1; // RULE_15
        charge_enable <= 1'b0; // RULE_15
    end
    else
    begin
        ceiling_converter_code <= next_ceiling_code;
        floor_converter_code <= next_floor_code;
        fill_rate_converter_code <= next_fill_code;
        // charging waits for a non-zero fill rate from the host
        battery_switch_gate <= (next_fill_code == 6'h00); // RULE_16
        charge_enable <= (next_fill_code != 6'h00);
    end
end

// -----------------------------------------------------------------
// register writes
// -----------------------------------------------------------------
always @(posedge core_clk)
begin
    if (srst)
    begin
        ceiling_word <= ceil_por(cell_count);
        floor_word <= floor_por(cell_count); // RULE_09
        fill_word <= `FILL_POR; // RULE_15
    end
    else if (write_pending && state == S_ACK && scl_fall && !start_seen && !stop_seen)
    begin
        // lands at the end of the acknowledge of the high byte
        case (cmd)
            `CMD_FILL: fill_word <= write_word; // RULE_17 RULE_22
            `CMD_CEIL: ceiling_word <= write_word; // RULE_22
            `CMD_FLOOR: floor_word <= write_word; // RULE_06 RULE_22
            default: ceiling_word <= ceiling_word;
        endcase
    end
end

// -----------------------------------------------------------------
// smbus target sequencer
// -----------------------------------------------------------------
always @(posedge core_clk)
begin
    if (srst)
    begin
        state <= S_IDLE;
        kind <= K_ADDR;
        bit_cnt <= 4'h0;
        shreg <= 8'h00;
        cmd <= 8'h00;
        lo_byte <= 8'h00;
        write_word <= 16'h0000;
        write_pending <= 1'b0;
        tx_after_ack <= 1'b0;
        idle_after_ack <= 1'b0;
        tx_hi <= 1'b0;
        master_ack <= 1'b0;
        sda_oe <= 1'b0;
    end
    else if (start_seen)
    begin
        // repeated start keeps the command code for a read
        state <= S_RX;
        kind <= K_ADDR;
        bit_cnt <= 4'h0;
        write_pending <= 1'b0;
        sda_oe <= 1'b0;
    end
    else if (stop_seen)
    begin
        state <= S_IDLE;
        write_pending <= 1'b0;
        sda_oe <= 1'b0;
    end
    else
    begin
        case (state)
            S_RX:
            begin
                if (scl_rise && bit_cnt != `BYTE_BITS)
                begin
                    shreg <= {shreg[6:0], sda_in}; // RULE_21
                    bit_cnt <= bit_cnt + 4'h1;
                end
                else if (scl_fall && bit_cnt == `BYTE_BITS)
                begin
                    bit_cnt <= 4'h0;
                    tx_after_ack <= 1'b0;
                    idle_after_ack <= 1'b0;
                    write_pending <= 1'b0;
                    case (kind)
                        K_ADDR:
                        begin
                            if (shreg[7:1] != `ADDR_SELF) // RULE_20
                                state <= S_IDLE;
                            else if (shreg[0] && !cmd_mapped(cmd))
                                state <= S_IDLE;
                            else
                            begin
                                state <= S_ACK;
                                sda_oe <= 1'b1;
                                kind <= K_CMD;
                                tx_after_ack <= shreg[0];
                            end
                        end
                        K_CMD:
                        begin
                            cmd <= shreg;
                            if (cmd_mapped(shreg))
                            begin
                                state <= S_ACK;
                                sda_oe <= 1'b1;
                                kind <= K_DLO;
                            end
                            else
                                state <= S_IDLE;
                        end
                        K_DLO:
                        begin
                            lo_byte <= shreg; // RULE_21
                            state <= S_ACK;
                            sda_oe <= 1'b1;
                            kind <= K_DHI;
                        end
                        default:
                        begin
                            if (ceil_rejected)
                                state <= S_IDLE; // RULE_18
                            else
                            begin
                                state <= S_ACK;
                                sda_oe <= 1'b1;
                                write_word <= rx_word;
                                write_pending <= 1'b1; // RULE_22
                                idle_after_ack <= 1'b1;
                            end
                        end
                    endcase
                end
            end
            S_ACK:
            begin
                if (scl_fall)
                begin
                    write_pending <= 1'b0;
                    bit_cnt <= 4'h0;
                    if (tx_after_ack)
                    begin
                        // low byte goes out first, msb first
                        state <= S_TX;
                        tx_hi <= 1'b0;
                        shreg <= read_word[7:0]; // RULE_21
                        sda_oe <= ~read_word[7];
                    end
                    else
                    begin
                        state <= idle_after_ack ? S_IDLE : S_RX;
                        sda_oe <= 1'b0;
                    end
                end
            end
            S_TX:
            begin
                if (scl_fall)
                begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == `LAST_TX_BIT)
                    begin
                        state <= S_TXACK;
                        sda_oe <= 1'b0;
                    end
                    else
                    begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                    end
                end
            end
            S_TXACK:
            begin
                if (scl_rise)
                    master_ack <= ~sda_in;
                else if (scl_fall)
                begin
                    bit_cnt <= 4'h0;
                    if (master_ack && !tx_hi)
                    begin
                        state <= S_TX;
                        tx_hi <= 1'b1;
                        shreg <= read_word[15:8];
                        sda_oe <= ~read_word[15];
                    end
                    else
                        state <= S_IDLE;
                end
            end
            default:
            begin
                state <= S_IDLE;
                sda_oe <= 1'b0;
            end
        endcase
    end
end

endmodule // charger_setpoint_registers

/* File: bench/charger_setpoint_registers_chk.sv */
// checker for the charger set-point register block, bound to its ports
// assumes one clock, synchronous active-high srst
module charger_setpoint_registers_chk (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // strap and bus
    input wire [1:0] cell_count,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // set points
    input wire [10:0] ceiling_converter_code,
    input wire [6:0] floor_converter_code,
    input wire [5:0] fill_rate_converter_code,
    input wire battery_switch_gate,
    input wire charge_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // expected values by strap
    // ----------------------------------------
    wire [6:0] floor_por = cell_count == 2'h1 ? 7'h18 : cell_count == 2'h2 ? 7'h24 : 7'h0c;
    wire [10:0] ceil_por = cell_count == 2'h1 ? 11'h200 : cell_count == 2'h2 ? 11'h300 : 11'h100;
    wire [10:0] ceil_top = cell_count == 2'h1 ? 11'h27f : cell_count == 2'h2 ? 11'h3ff : 11'h17f;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    sequence s_scl_high2;
        scl_in ##1 scl_in;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_fill_off: assert property (disable iff (1'b0) srst |=> fill_rate_converter_code == 6'h00
        && battery_switch_gate && !charge_enable) else $error("fill rate not cleared by reset");
    a_reset_floor_por: assert property (disable iff (1'b0) srst |=> floor_converter_code == $past(floor_por))
        else $error("floor code wrong after reset");
    a_reset_ceil_por: assert property (disable iff (1'b0) srst |=> ceiling_converter_code == $past(ceil_por))
        else $error("ceiling code wrong after reset");
    a_ceil_within_limit: assert property (ceiling_converter_code <= ceil_top)
        else $error("ceiling code above strap limit");
    a_floor_clamped: assert property (floor_converter_code <= 7'h4b)
        else $error("floor code above clamp");
    a_gate_follows_fill: assert property (battery_switch_gate == (fill_rate_converter_code == 6'h00))
        else $error("gate disagrees with fill code");
    a_enable_opposes_gate: assert property (charge_enable != battery_switch_gate)
        else $error("charge enable disagrees with gate");
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_sda_held_scl_high: assert property (s_scl_high2 |-> $stable(sda_oe))
        else $error("data changed while clock high");
    a_codes_move_scl_low: assert property (($changed(fill_rate_converter_code)
        || $changed(floor_converter_code) || $changed(ceiling_converter_code)) |-> !$past(scl_in))
        else $error("code changed outside clock low");
endmodule // charger_setpoint_registers_chk

bind charger_setpoint_registers charger_setpoint_registers_chk charger_setpoint_registers_chk_inst (
    .core_clk(core_clk), .srst(srst), .cell_count(cell_count), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ceiling_converter_code(ceiling_converter_code),
    .floor_converter_code(floor_converter_code), .fill_rate_converter_code(fill_rate_converter_code),
    .battery_switch_gate(battery_switch_gate), .charge_enable(charge_enable));

/* File: bench/smbus_host_model.sv */
// smbus host model: drives the clock line and pulls data low
// assumes the bench resolves the pulled-up data wire
module smbus_host_model (
    // clock
    input wire logic core_clk,
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda,
    // read results
    output logic rd_valid,
    output logic [15:0] rd_word
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_valid = 1'b0;
        rd_word = 16'h0000;
    end
    // ----------------------------------------
    // bit level, each phase four cycles
    // ----------------------------------------
    task automatic half();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    task automatic bit_out(input logic b);
        sda_low = !b;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        b = sda;
        scl = 1'b0;
    endtask
    // ----------------------------------------
    // byte and word level
    // ----------------------------------------
    task automatic byte_out(input logic [7:0] v, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_out(v[i]);
        bit_in(a);
        ok = ok & !a;
    endtask
    task automatic byte_in(input logic nak, output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            bit_in(v[i]);
        bit_out(nak);
    endtask
    task automatic write_word(input logic [7:0] a, c, input logic [15:0] w, input logic full, output logic ok);
        ok = 1'b1;
        start();
        byte_out(a, ok);
        byte_out(c, ok);
        byte_out(w[7:0], ok);
        if (full)
            byte_out(w[15:8], ok);
        stop();
    endtask
    task automatic read_word(input logic [7:0] c);
        logic ok;
        logic [7:0] lo;
        logic [7:0] hi;
        ok = 1'b1;
        start();
        byte_out(8'h12, ok);
        byte_out(c, ok);
        start();
        byte_out(8'h13, ok);
        byte_in(1'b0, lo);
        byte_in(1'b1, hi);
        stop();
        rd_word = {hi, lo};
        rd_valid = 1'b1;
        @(posedge core_clk);
        #1 rd_valid = 1'b0;
    endtask
endmodule // smbus_host_model

/* File: bench/charger_setpoint_registers_bench.sv */
// self-checking bench for the charger set-point registers
// assumes the host model as the only bus master
`include "charger_defines.vh"
module charger_setpoint_registers_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] cell_count = 2'h0;
    logic scl;
    logic sda_low;
    logic rd_valid;
    logic [15:0] rd_word;
    logic sda_out;
    logic sda_oe;
    logic [10:0] ceil_code;
    logic [6:0] floor_code;
    logic [5:0] fill_code;
    logic gate;
    logic chg_en;
    logic ok;
    logic [15:0] lim, pc, pf, cw, fw, iw, w;
    logic [15:0] tw [10] = '{16'h0, 16'h4b00, 16'h4bff, 16'hff00, 16'h4c00,
                             16'h0, 16'h0080, 16'h0081, 16'h2000, 16'h1f80};
    logic [15:0] expq [$];
    int fails = 0;
    int n_compared = 0;
    // pulled-up open-drain data wire
    wire sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
    initial
    begin
        forever #5 core_clk = !core_clk;
    end
    charger_setpoint_registers charger_setpoint_registers_inst (.core_clk(core_clk), .srst(srst),
        .cell_count(cell_count), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .ceiling_converter_code(ceil_code), .floor_converter_code(floor_code),
        .fill_rate_converter_code(fill_code), .battery_switch_gate(gate), .charge_enable(chg_en));
    smbus_host_model smbus_host_model_inst (.core_clk(core_clk), .scl(scl), .sda_low(sda_low), .sda(sda),
        .rd_valid(rd_valid), .rd_word(rd_word));
    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", name, e, g);
            fails++;
        end
    endtask
    task automatic codes(input logic [15:0] c, input logic [15:0] f, input logic [15:0] i);
        logic [5:0] e;
        e = i <= `FILL_ZERO_MA ? 6'h00 : i > `FILL_MAX_MA ? `FILL_FULL_CODE : i[12:7];
        cmp("ceiling", c < `CEIL_MIN_MV ? 16'h0 : 16'(c[14:4]), 16'(ceil_code));
        cmp("floor", 16'(f[14:8] > `FLOOR_MAX_CODE ? `FLOOR_MAX_CODE : f[14:8]), 16'(floor_code));
        cmp("fill", 16'(e), 16'(fill_code));
        cmp("gate", 16'(e == 6'h00), 16'(gate));
        cmp("enable", 16'(e != 6'h00), 16'(chg_en));
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] v, input logic e);
        smbus_host_model_inst.write_word(8'h12, c, v, 1'b1, ok);
        cmp("ack", 16'(e), 16'(ok));
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        expq.push_back(e);
        smbus_host_model_inst.read_word(c);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // result watcher and watchdog
    // ----------------------------------------
    always @(posedge core_clk)
        if (rd_valid)
            cmp("read word", expq.size() > 0 ? expq.pop_front() : 16'hxxxx, rd_word);
    initial
    begin
        #500000;
        fails++;
        conclude();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(87318));
        for (int cc = 0; cc < 4; cc++)
        begin
            lim = cc == 1 ? `CEIL_REJ_2 : cc == 2 ? `CEIL_REJ_3 : `CEIL_REJ_1;
            pc = cc == 1 ? `CEIL_POR_2 : cc == 2 ? `CEIL_POR_3 : `CEIL_POR_1;
            pf = cc == 1 ? `FLOOR_POR_2 : cc == 2 ? `FLOOR_POR_3 : `FLOOR_POR_1;
            srst = 1'b1;
            cell_count = cc[1:0];
            repeat (4) @(posedge core_clk);
            #1 srst = 1'b0;
            codes(pc, pf, `FILL_POR);
            rd(`CMD_CEIL, pc);
            rd(`CMD_FLOOR, pf);
            rd(`CMD_FILL, `FILL_POR);
            wr(`CMD_CEIL, lim - 16'h10, 1'b1);
            wr(`CMD_CEIL, lim, 1'b0);
            codes(lim - 16'h10, pf, `FILL_POR);
            rd(`CMD_CEIL, lim - 16'h10);
        end
        cw = lim - 16'h10;
        fw = pf;
        iw = `FILL_POR;
        for (int i = 0; i < 10; i++)
        begin
            w = (i % 5 == 0) ? 16'($urandom) : tw[i];
            if (i < 5)
                fw = w;
            else
                iw = w;
            wr(i < 5 ? `CMD_FLOOR : `CMD_FILL, w, 1'b1);
            codes(cw, fw, iw);
            rd(i < 5 ? `CMD_FLOOR : `CMD_FILL, w);
        end
        // a ceiling request under 1024mV turns the regulator off
        cw = 16'h03f0;
        wr(`CMD_CEIL, cw, 1'b1);
        smbus_host_model_inst.write_word(8'h12, `CMD_FILL, 16'h0000, 1'b0, ok);
        codes(cw, fw, iw);
        smbus_host_model_inst.write_word(8'h14, `CMD_FILL, 16'h0000, 1'b1, ok);
        cmp("ack", 16'h0, 16'(ok));
        wr(8'h3d, 16'h0000, 1'b0);
        codes(cw, fw, iw);
        rd(`CMD_FILL, iw);
        repeat (4) @(posedge core_clk);
        cmp("queue left", 16'h0, 16'(expq.size()));
        conclude();
    end
endmodule // charger_setpoint_registers_bench
